// *** pkg/tpcm_pkg.sv ***
package tpcm_pkg;

    // ****************************************
    // memory geometry
    // ****************************************
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned NV_DEPTH    = 128;
    localparam int unsigned NV_ADDR_W   = 7;
    localparam logic [7:0]  UPPER_BASE  = 8'h80;
    localparam logic [7:0]  IDLE_RESP   = 8'h00;
    localparam logic [7:0]  BUSY_RESP   = 8'h01;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  NV_ERASED   = 8'hFF;

    // ****************************************
    // control page special locations
    // ****************************************
    localparam logic [7:0]  TEMP_HI_ADDR  = 8'h0A;
    localparam logic [7:0]  TEMP_LO_ADDR  = 8'h0B;
    localparam logic [7:0]  MODE_ADDR     = 8'h12;
    localparam logic [7:0]  TRIG_ADDR     = 8'h18;
    localparam logic [7:0]  FRAMES_ADDR   = 8'h19;
    localparam logic [7:0]  INTEG_ADDR    = 8'h1A;

    // ****************************************
    // timing (25 MHz clock)
    // ****************************************
    localparam int unsigned CLK_MHZ       = 25;
    localparam int unsigned NV_PROG_US    = 4;
    localparam int unsigned NV_PROG_CYC   = NV_PROG_US * CLK_MHZ;
    localparam int unsigned ROW_READ_CYC  = 16;
    localparam logic [2:0]  TEMP_ROWS_UFS = 3'h1;
    localparam logic [2:0]  TEMP_ROWS_GBI = 3'h2;
    localparam logic [2:0]  TEMP_ROWS_STD = 3'h4;
    localparam logic [1:0]  MODE_UFS      = 2'h1;
    localparam logic [1:0]  MODE_GBI      = 2'h2;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        nv_prog;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } tpcm_req_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  rdata;
        logic [7:0]  status;
    } tpcm_rsp_s;

    typedef enum logic [2:0] {
        ST_BOOT  = 3'b000,
        ST_IDLE  = 3'b001,
        ST_PROG  = 3'b010,
        ST_ACQ   = 3'b011,
        ST_ROWS  = 3'b100
    } tpcm_state_e;

endpackage : tpcm_pkg

// *** logic/tpcm_nv_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpcm_nv_store
    import tpcm_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 we_i,
    input  wire logic [NV_ADDR_W-1:0] waddr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic [NV_ADDR_W-1:0] raddr_i,
    output logic      [7:0]           rdata_o
);

    // ****************************************
    // non-volatile array model, registered read
    // ****************************************
    logic [7:0] mem [NV_DEPTH];

    initial
    begin
        for (int i = 0; i < NV_DEPTH; i++)
        begin
            mem[i] = NV_ERASED;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule : tpcm_nv_store
`default_nettype wire

// *** logic/tpcm_config_mem.sv ***
// Functional notes
// - 256 byte-wide locations, addresses 00 to FF
// - upper half backed by non-volatile store
// - multi-byte values stored MSB at lower address
// - control page resets to fixed defaults
// - RAM page reloaded from store on reset
// - 128-byte non-volatile store for parameters
// - idle answer zero once ready
// - trigger runs whole measurement unattended
// - per-frame settings such as integration time
// - temperature cleared per frame, valid after rows
`timescale 1ns/1ps
`default_nettype none
module tpcm_config_mem
    import tpcm_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire tpcm_req_s  req_i,
    input  wire logic [13:0] temp_i,
    input  wire logic       row_done_i,
    output tpcm_rsp_s       rsp_o,
    output logic            ready_o,
    output logic            acq_busy_o,
    output logic            frame_start_o,
    output logic [7:0]      integ_o,
    output logic [7:0]      mode_o
);

    // ****************************************
    // state
    // ****************************************
    tpcm_state_e          state;
    tpcm_state_e          next_state;
    logic [7:0]           ctrl [128];
    logic [7:0]           ram  [128];
    logic [7:0]           boot_cnt;
    logic [7:0]           next_boot_cnt;
    logic [7:0]           prog_cnt;
    logic [7:0]           next_prog_cnt;
    logic [7:0]           frames_left;
    logic [7:0]           next_frames_left;
    logic [2:0]           rows_cnt;
    logic [2:0]           next_rows_cnt;
    logic [2:0]           rows_need;
    logic [7:0]           prog_addr;
    logic [7:0]           prog_data;
    logic [7:0]           next_prog_addr;
    logic [7:0]           next_prog_data;
    tpcm_rsp_s            next_rsp;
    logic                 nv_we;
    logic [NV_ADDR_W-1:0] nv_raddr;
    logic [7:0]           nv_rdata;
    logic                 boot_wr;
    logic                 host_ok;

    tpcm_nv_store u_nv (
        .sys_clk_i (sys_clk_i),
        .we_i      (nv_we),
        .waddr_i   (prog_addr[NV_ADDR_W-1:0]),
        .wdata_i   (prog_data),
        .raddr_i   (nv_raddr),
        .rdata_o   (nv_rdata)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    assign host_ok  = (state == ST_IDLE) || (state == ST_ACQ) || (state == ST_ROWS);
    assign nv_raddr = boot_cnt[NV_ADDR_W-1:0];
    assign boot_wr  = (state == ST_BOOT) && (boot_cnt != 8'h00);
    assign nv_we    = (state == ST_PROG) && (prog_cnt == 8'(NV_PROG_CYC - 1));

    always_comb
    begin
        unique case (mode_o[1:0])
            MODE_UFS: rows_need = TEMP_ROWS_UFS;
            MODE_GBI: rows_need = TEMP_ROWS_GBI;
            default:  rows_need = TEMP_ROWS_STD;
        endcase
    end

    always_comb
    begin
        next_state       = state;
        next_boot_cnt    = boot_cnt;
        next_prog_cnt    = prog_cnt;
        next_prog_addr   = prog_addr;
        next_prog_data   = prog_data;
        next_frames_left = frames_left;
        next_rows_cnt    = rows_cnt;
        next_rsp         = '0;
        unique case (state)
            ST_BOOT:
            begin
                next_boot_cnt = boot_cnt + 8'h01;
                if (boot_cnt == 8'(NV_DEPTH))
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_PROG:
            begin
                next_prog_cnt = prog_cnt + 8'h01;
                if (nv_we)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_ACQ:
            begin
                next_rows_cnt = 3'h0;
                next_state    = ST_ROWS;
            end
            ST_ROWS:
            begin
                if (row_done_i && rows_cnt != rows_need)
                begin
                    next_rows_cnt = rows_cnt + 3'h1;
                end
                if (row_done_i && rows_cnt + 3'h1 >= rows_need)
                begin
                    next_frames_left = frames_left - 8'h01;
                    next_state = (frames_left > 8'h01) ? ST_ACQ : ST_IDLE;
                end
            end
            default:
            begin
                if (req_i.nv_prog && req_i.addr[7])
                begin
                    next_prog_addr = req_i.addr;
                    next_prog_data = req_i.wdata;
                    next_prog_cnt  = 8'h00;
                    next_state     = ST_PROG;
                end
                else if (req_i.wr && req_i.addr == TRIG_ADDR && req_i.wdata[0])
                begin
                    next_frames_left = (ctrl[FRAMES_ADDR[6:0]] == 8'h00) ? 8'h01
                                       : ctrl[FRAMES_ADDR[6:0]];
                    next_state       = ST_ACQ;
                end
            end
        endcase
        if (req_i.rd || req_i.wr || req_i.nv_prog)
        begin
            next_rsp.valid  = 1'b1;
            next_rsp.status = host_ok && state != ST_PROG ? IDLE_RESP : BUSY_RESP;
            next_rsp.rdata  = req_i.addr[7] ? ram[req_i.addr[6:0]]
                              : ctrl[req_i.addr[6:0]];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state       <= ST_BOOT;
            boot_cnt    <= 8'h00;
            prog_cnt    <= 8'h00;
            prog_addr   <= 8'h00;
            prog_data   <= 8'h00;
            frames_left <= 8'h00;
            rows_cnt    <= 3'h0;
            rsp_o       <= '0;
        end
        else
        begin
            state       <= next_state;
            boot_cnt    <= next_boot_cnt;
            prog_cnt    <= next_prog_cnt;
            prog_addr   <= next_prog_addr;
            prog_data   <= next_prog_data;
            frames_left <= next_frames_left;
            rows_cnt    <= next_rows_cnt;
            rsp_o       <= next_rsp;
        end
    end

    // ****************************************
    // control page, reset to defaults
    // ****************************************
    generate
        for (genvar g = 0; g < 128; g++)
        begin : g_ctrl
            logic [7:0] next_val;
            always_comb
            begin
                next_val = ctrl[g];
                if (req_i.wr && host_ok && req_i.addr == 8'(g))
                begin
                    next_val = req_i.wdata;
                end
                if (8'(g) == TEMP_HI_ADDR)
                begin
                    if (state == ST_ACQ)
                        next_val = 8'h00;
                    else if (state == ST_ROWS && row_done_i && rows_cnt + 3'h1 == rows_need)
                        next_val = {2'b00, temp_i[13:8]};
                end
                if (8'(g) == TEMP_LO_ADDR)
                begin
                    if (state == ST_ACQ)
                        next_val = 8'h00;
                    else if (state == ST_ROWS && row_done_i && rows_cnt + 3'h1 == rows_need)
                        next_val = temp_i[7:0];
                end
            end
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    ctrl[g] <= CTRL_RESET;
                else
                    ctrl[g] <= next_val;
            end
        end
    endgenerate

    // ****************************************
    // RAM page, shadow of the store
    // ****************************************
    generate
        for (genvar g = 0; g < 128; g++)
        begin : g_ram
            logic [7:0] next_val;
            always_comb
            begin
                next_val = ram[g];
                if (boot_wr && boot_cnt == 8'(g + 1))
                    next_val = nv_rdata;
                else if (req_i.wr && host_ok && req_i.addr == (UPPER_BASE | 8'(g)))
                    next_val = req_i.wdata;
                else if (nv_we && prog_addr == (UPPER_BASE | 8'(g)))
                    next_val = prog_data;
            end
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    ram[g] <= 8'h00;
                else
                    ram[g] <= next_val;
            end
        end
    endgenerate

    assign ready_o       = host_ok;
    assign acq_busy_o    = (state == ST_ACQ) || (state == ST_ROWS);
    assign frame_start_o = (state == ST_ACQ);
    assign integ_o       = ctrl[INTEG_ADDR[6:0]];
    assign mode_o        = ctrl[MODE_ADDR[6:0]];

endmodule : tpcm_config_mem
`default_nettype wire

// *** sim/tpcm_config_mem_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpcm_config_mem_chk
    import tpcm_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire tpcm_req_s  req_i,
    input wire tpcm_rsp_s  rsp_o,
    input wire logic       ready_o,
    input wire logic       acq_busy_o,
    input wire logic       frame_start_o,
    input wire logic [7:0] integ_o,
    input wire logic [7:0] mode_o
);
    logic [7:0] up_cnt;
    logic [7:0] next_up_cnt;
    logic       any_req;
    logic       wr_ok;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    assign any_req = req_i.rd || req_i.wr || req_i.nv_prog;
    assign wr_ok = req_i.wr && ready_o;
    assign next_up_cnt = (up_cnt == 8'hFF) ? up_cnt : up_cnt + 8'h01;
    always_ff @(posedge sys_clk_i or posedge rst_i)
        if (rst_i)
            up_cnt <= 8'h00;
        else
            up_cnt <= next_up_cnt;
    AST_RSP_AFTER: assert property (any_req |=> rsp_o.valid)
        else $error("request unanswered");
    AST_RSP_CAUSE: assert property (rsp_o.valid |-> $past(any_req))
        else $error("answer without request");
    AST_BOOT_HOLD: assert property (up_cnt < 8'h64 |-> !ready_o)
        else $error("ready before store copy");
    AST_IDLE_READY: assert property (rsp_o.valid && rsp_o.status == IDLE_RESP
        |-> $past(ready_o)) else $error("idle while not ready");
    AST_INTEG_WR: assert property (wr_ok && req_i.addr == INTEG_ADDR
        |=> integ_o == $past(req_i.wdata)) else $error("integration not taken");
    AST_MODE_WR: assert property (wr_ok && req_i.addr == MODE_ADDR
        |=> mode_o == $past(req_i.wdata)) else $error("mode not taken");
    AST_TRIG_RUN: assert property (wr_ok && req_i.addr == TRIG_ADDR && req_i.wdata[0]
        && !acq_busy_o |=> frame_start_o && acq_busy_o) else $error("no start");
    AST_NV_HOLD: assert property (req_i.nv_prog && ready_o && !acq_busy_o && req_i.addr[7]
        |=> !ready_o [*8]) else $error("programming too short");
endmodule : tpcm_config_mem_chk
bind tpcm_config_mem tpcm_config_mem_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .req_i(req_i), .rsp_o(rsp_o), .ready_o(ready_o), .acq_busy_o(acq_busy_o),
    .frame_start_o(frame_start_o), .integ_o(integ_o), .mode_o(mode_o));
`default_nettype wire

// *** sim/tpcm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpcm_host_model
    import tpcm_pkg::*;
(
    input  wire logic      sys_clk_i,
    input  wire tpcm_rsp_s rsp_i,
    output var tpcm_req_s  req_o
);
    initial req_o = '0;
    // op is rd, wr, nv_prog; released fields show inverted data
    task automatic xfer(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d,
                        output tpcm_rsp_s rsp);
        @(negedge sys_clk_i);
        req_o = {op, a, d};
        @(negedge sys_clk_i);
        rsp = rsp_i;
        req_o = {3'b000, ~a, ~d};
    endtask : xfer
    task automatic poll(output logic ok);
        tpcm_rsp_s r;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            xfer(3'b100, 8'h00, 8'h00, r);
            ok = r.valid === 1'b1 && r.status === IDLE_RESP;
        end
    endtask : poll
endmodule : tpcm_host_model
`default_nettype wire

// *** sim/tpcm_config_mem_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpcm_config_mem_tb
    import tpcm_pkg::*;
;
    logic        sys_clk_i;
    logic        rst_i;
    tpcm_req_s   req;
    tpcm_rsp_s   rsp;
    tpcm_rsp_s   r;
    logic [13:0] temp;
    logic        row_done, ready, busy, fstart, ok;
    logic [7:0]  integ, mode;
    int          n_errors, compares, n_frames;
    logic [7:0]  al [8] = '{8'h00, 8'h7F, 8'h80, 8'hFF, 8'hA0, 8'hA1, 8'hA2, 8'hA3};
    tpcm_config_mem dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .temp_i(temp),
        .row_done_i(row_done), .rsp_o(rsp), .ready_o(ready), .acq_busy_o(busy),
        .frame_start_o(fstart), .integ_o(integ), .mode_o(mode));
    tpcm_host_model host (.sys_clk_i(sys_clk_i), .rsp_i(rsp), .req_o(req));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
        if (fstart === 1'b1)
            n_frames++;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.xfer(3'b100, a, 8'h00, r);
        chk(r.rdata, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic nv);
        host.xfer({1'b0, ~nv, nv}, a, d, r);
    endtask : wr
    task automatic boot();
        @(negedge sys_clk_i);
        rst_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        rst_i = 1'b0;
        host.poll(ok);
        chk({7'h00, ok}, 8'h01);
    endtask : boot
    task automatic rows(input int n);
        repeat (n)
        begin
            @(negedge sys_clk_i);
            row_done = 1'b1;
            @(negedge sys_clk_i);
            row_done = 1'b0;
            repeat (3) @(negedge sys_clk_i);
        end
    endtask : rows
    task automatic t_rw();
        rd(MODE_ADDR, CTRL_RESET);
        rd(8'h80, NV_ERASED);
        for (int i = 0; i < 8; i++)
            wr(al[i], al[i] ^ 8'h5A, 1'b0);
        for (int i = 0; i < 8; i++)
            rd(al[i], al[i] ^ 8'h5A);
        wr(INTEG_ADDR, 8'h5A, 1'b0);
        chk(integ, 8'h5A);
    endtask : t_rw
    task automatic t_reload();
        wr(8'h90, 8'h3C, 1'b0);
        wr(8'h05, 8'hA5, 1'b0);
        wr(8'h81, 8'hC3, 1'b1);
        wr(8'h05, 8'h11, 1'b0);
        chk(r.status, BUSY_RESP);
        host.poll(ok);
        rd(8'h05, 8'hA5);
        boot();
        rd(8'h90, NV_ERASED);
        rd(8'h05, CTRL_RESET);
        rd(8'h81, 8'hC3);
    endtask : t_reload
    task automatic t_temp();
        temp = 14'h2ABC;
        wr(MODE_ADDR, {6'h00, MODE_GBI}, 1'b0);
        chk(mode, {6'h00, MODE_GBI});
        wr(FRAMES_ADDR, 8'h02, 1'b0);
        n_frames = 0;
        wr(TRIG_ADDR, 8'h01, 1'b0);
        chk({7'h00, busy}, 8'h01);
        rd(TEMP_HI_ADDR, 8'h00);
        rows(1);
        rd(TEMP_HI_ADDR, 8'h00);
        wr(INTEG_ADDR, 8'h33, 1'b0);
        chk(integ, 8'h33);
        rows(3);
        rd(TEMP_HI_ADDR, 8'h2A);
        rd(TEMP_LO_ADDR, 8'hBC);
        chk({7'h00, busy}, 8'h00);
        chk(n_frames[7:0], 8'h02);
        temp = 14'h1357;
        wr(MODE_ADDR, {6'h00, MODE_UFS}, 1'b0);
        wr(FRAMES_ADDR, 8'h00, 1'b0);
        wr(TRIG_ADDR, 8'h01, 1'b0);
        rd(TEMP_HI_ADDR, 8'h00);
        rows(1);
        rd(TEMP_HI_ADDR, 8'h13);
        rd(TEMP_LO_ADDR, 8'h57);
        chk(n_frames[7:0], 8'h03);
        wr(FRAMES_ADDR, 8'h04, 1'b0);
        wr(TRIG_ADDR, 8'h01, 1'b0);
        rows(4);
        chk(n_frames[7:0], 8'h07);
        chk({7'h00, busy}, 8'h00);
    endtask : t_temp
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    initial
    begin
        rst_i = 1'b1;
        row_done = 1'b0;
        temp = '0;
        n_errors = 0;
        compares = 0;
        n_frames = 0;
        boot();
        t_rw();
        t_reload();
        t_temp();
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        end_sim();
    end
endmodule : tpcm_config_mem_tb
`default_nettype wire
